// ### core/iorg_defs.svh
// Constants for the inertial output register bank
`ifndef IORG_DEFS_SVH
`define IORG_DEFS_SVH

`define IORG_WORD_W 16
`define IORG_AXES 6
`define IORG_AXIS_W 3
`define IORG_GYRO_AXES 3'h3
`define IORG_CNT_W 4
`define IORG_CNT_ZERO 4'h0
`define IORG_CNT_LAST 4'hf
`define IORG_CMD_WR_BIT 15
`define IORG_ADDR_MSB 14
`define IORG_ADDR_LSB 8
`define IORG_RESP_RST 16'h0000
`define IORG_BANK_RST 32'h0000_0000
`define IORG_FIRST_WORD 6'h02

`define IORG_X_RATE_FINE_ADDR 7'h04
`define IORG_X_RATE_COARSE_ADDR 7'h06
`define IORG_Y_RATE_FINE_ADDR 7'h08
`define IORG_Y_RATE_COARSE_ADDR 7'h0a
`define IORG_Z_RATE_FINE_ADDR 7'h0c
`define IORG_Z_RATE_COARSE_ADDR 7'h0e
`define IORG_X_ACCEL_FINE_ADDR 7'h10
`define IORG_X_ACCEL_COARSE_ADDR 7'h12
`define IORG_Y_ACCEL_FINE_ADDR 7'h14
`define IORG_Y_ACCEL_COARSE_ADDR 7'h16
`define IORG_Z_ACCEL_FINE_ADDR 7'h18
`define IORG_FIRST_ADDR 7'h04
`define IORG_LAST_ADDR 7'h19

`endif

// ### core/iorg_pkg.sv
// Types for the inertial output register bank
`include "iorg_defs.svh"
package iorg_pkg;
  typedef enum logic [1:0] {
    IORG_IDLE = 2'b01,
    IORG_SHIFT = 2'b10
  } iorg_state_e;
  typedef logic [`IORG_WORD_W-1:0] iorg_word_t;
  typedef logic [`IORG_AXES-1:0][2*`IORG_WORD_W-1:0] iorg_bank_t;
endpackage : iorg_pkg

// ### core/iorg_snap.sv
// Sample bank with per-axis partner-word latch
`timescale 1ns/100ps
`include "iorg_defs.svh"
module iorg_snap import iorg_pkg::*; #(
  parameter int AXES = `IORG_AXES,
  parameter int W = `IORG_WORD_W,
  parameter int AW = `IORG_AXIS_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [AXES-1:0][2*W-1:0] sample_in,
  input wire logic rd_stb_in,
  input wire logic [AW-1:0] rd_axis_in,
  input wire logic rd_coarse_in,
  output logic [W-1:0] rd_word_out,
  output logic partner_hit_out,
  output logic [AXES-1:0][2*W-1:0] bank_out
);
  logic [AXES-1:0][2*W-1:0] bank_reg;
  logic [AXES-1:0][W-1:0] partner_reg;
  logic [AXES-1:0] armed_reg;
  logic [AXES-1:0] armed_coarse_reg;
  logic [AXES-1:0] hit_vec;
  logic [AXES-1:0] sel_vec;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      assign sel_vec[g] = rd_stb_in && (rd_axis_in == AW'(g));
      assign hit_vec[g] = armed_reg[g] && (armed_coarse_reg[g] != rd_coarse_in);

      // Whole 32-bit result of one update lands at once
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          bank_reg[g] <= `IORG_BANK_RST;
        end else if (sample_valid_in) begin
          bank_reg[g] <= sample_in[g];
        end
      end

      // First half read keeps the other half of the same update
      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          armed_reg[g] <= 1'b0;
          armed_coarse_reg[g] <= 1'b0;
          partner_reg[g] <= '0;
        end else if (sel_vec[g]) begin
          if (hit_vec[g]) begin
            armed_reg[g] <= 1'b0;
          end else begin
            armed_reg[g] <= 1'b1;
            armed_coarse_reg[g] <= rd_coarse_in;
            partner_reg[g] <= rd_coarse_in ? bank_reg[g][W-1:0] : bank_reg[g][2*W-1:W];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    rd_word_out = '0;
    partner_hit_out = 1'b0;
    for (int i = 0; i < AXES; i++) begin
      if (rd_axis_in == AW'(i)) begin
        partner_hit_out = hit_vec[i];
        if (hit_vec[i]) begin
          rd_word_out = partner_reg[i];
        end else if (rd_coarse_in) begin
          rd_word_out = bank_reg[i][2*W-1:W];
        end else begin
          rd_word_out = bank_reg[i][W-1:0];
        end
      end
    end
  end

  assign bank_out = bank_reg;
endmodule : iorg_snap

// ### core/iorg_top.sv
// Serial-port output register bank for rate and acceleration results
// Operation
// - x rate fine word at 0x04
// - x rate coarse word at 0x06
// - y rate fine word at 0x08
// - y rate coarse word at 0x0a
// - z rate fine word at 0x0c
// - z rate coarse word at 0x0e
// - rate coarse over fine forms 32 bits
// - x and y accel coarse over fine form 32 bits; z accel coarse is not mapped
// - x accel fine word at 0x10
// - x accel coarse word at 0x12
// - y accel fine word at 0x14
// - y accel coarse word at 0x16
// - z accel fine word at 0x18
`timescale 1ns/100ps
`include "iorg_defs.svh"
module iorg_top import iorg_pkg::*; #(
  parameter int W = `IORG_WORD_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [2*W-1:0] x_rate_in,
  input wire logic [2*W-1:0] y_rate_in,
  input wire logic [2*W-1:0] z_rate_in,
  input wire logic [2*W-1:0] x_accel_in,
  input wire logic [2*W-1:0] y_accel_in,
  input wire logic [2*W-1:0] z_accel_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  output logic frame_err_out
);
  iorg_state_e state_reg;
  logic sclk_d_reg;
  logic [`IORG_CNT_W-1:0] bit_cnt_reg;
  logic [W-1:0] rx_reg;
  logic [W-1:0] tx_reg;
  logic [W-1:0] resp_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic active;
  logic cmd_done;
  logic [W-1:0] cmd_word;
  logic cmd_wr;
  logic [6:0] cmd_addr;
  logic [6:0] word_addr;
  logic [5:0] rd_idx;
  logic [`IORG_AXIS_W-1:0] rd_axis;
  logic rd_coarse;
  logic mapped;
  logic rd_stb;
  logic [W-1:0] rd_word;
  logic partner_hit;
  iorg_bank_t sample_bus;
  iorg_bank_t bank_w;

  assign sclk_rise = spi_sclk_in && !sclk_d_reg;
  assign sclk_fall = !spi_sclk_in && sclk_d_reg;
  assign active = (state_reg == IORG_SHIFT) && !spi_cs_n_in;
  assign cmd_done = active && sclk_rise && (bit_cnt_reg == `IORG_CNT_LAST);
  assign cmd_word = {rx_reg[W-2:0], spi_mosi_in};
  assign cmd_wr = cmd_word[`IORG_CMD_WR_BIT];
  assign cmd_addr = cmd_word[`IORG_ADDR_MSB:`IORG_ADDR_LSB];
  assign word_addr = {cmd_addr[6:1], 1'b0};
  assign rd_idx = cmd_addr[6:1] - `IORG_FIRST_WORD;
  assign rd_axis = rd_idx[3:1];
  assign rd_coarse = rd_idx[0];
  assign mapped = (cmd_addr >= `IORG_FIRST_ADDR) && (cmd_addr <= `IORG_LAST_ADDR);
  assign rd_stb = cmd_done && !cmd_wr && mapped;
  assign sample_bus = {z_accel_in, y_accel_in, x_accel_in, z_rate_in, y_rate_in, x_rate_in};

  iorg_snap #(
    .AXES(`IORG_AXES),
    .W(W),
    .AW(`IORG_AXIS_W)
  ) u_snap (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_bus),
    .rd_stb_in(rd_stb),
    .rd_axis_in(rd_axis),
    .rd_coarse_in(rd_coarse),
    .rd_word_out(rd_word),
    .partner_hit_out(partner_hit),
    .bank_out(bank_w)
  );

  // Frame state follows chip select
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= IORG_IDLE;
    end else begin
      unique case (state_reg)
        IORG_IDLE: begin
          if (!spi_cs_n_in) begin
            state_reg <= IORG_SHIFT;
          end
        end
        IORG_SHIFT: begin
          if (spi_cs_n_in) begin
            state_reg <= IORG_IDLE;
          end
        end
      endcase
    end
  end

  // Serial clock edge history
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= spi_sclk_in;
    end
  end

  // Receive shift and bit count on rising edges
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bit_cnt_reg <= `IORG_CNT_ZERO;
      rx_reg <= `IORG_RESP_RST;
    end else if (!active) begin
      bit_cnt_reg <= `IORG_CNT_ZERO;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      rx_reg <= cmd_word;
    end
  end

  // Read answer is fetched at end of word, sent in the next word
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      resp_reg <= `IORG_RESP_RST;
    end else if (cmd_done) begin
      if (rd_stb) begin
        resp_reg <= rd_word;
      end else begin
        resp_reg <= `IORG_RESP_RST;
      end
    end
  end

  // Transmit shift on falling edges
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_reg <= `IORG_RESP_RST;
      spi_miso_out <= 1'b0;
    end else if (active && sclk_fall) begin
      if (bit_cnt_reg == `IORG_CNT_ZERO) begin
        spi_miso_out <= resp_reg[W-1];
        tx_reg <= {resp_reg[W-2:0], 1'b0};
      end else begin
        spi_miso_out <= tx_reg[W-1];
        tx_reg <= {tx_reg[W-2:0], 1'b0};
      end
    end
  end

  // Output driven only while selected
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_oe_out <= !spi_cs_n_in;
    end
  end

  // Frame ending off a word boundary is flagged until a clean frame ends
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_err_out <= 1'b0;
    end else if ((state_reg == IORG_SHIFT) && spi_cs_n_in) begin
      frame_err_out <= (bit_cnt_reg != `IORG_CNT_ZERO);
    end
  end

  // Checking aids
  logic [`IORG_AXIS_W-1:0] last_axis_reg;
  logic [2*W-1:0] pair_exp_reg;
  logic [W-1:0] exp_half;
  logic upd_since_reg;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_axis_reg <= '0;
      pair_exp_reg <= `IORG_BANK_RST;
    end else if (rd_stb && !partner_hit) begin
      last_axis_reg <= rd_axis;
      pair_exp_reg <= bank_w[rd_axis];
    end
  end

  // New update seen since the last first-half read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      upd_since_reg <= 1'b0;
    end else if (sample_valid_in) begin
      upd_since_reg <= 1'b1;
    end else if (rd_stb && !partner_hit) begin
      upd_since_reg <= 1'b0;
    end
  end

  assign exp_half = rd_coarse ? pair_exp_reg[2*W-1:W] : pair_exp_reg[W-1:0];

  default clocking dflt_cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  x_rate_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_X_RATE_FINE_ADDR
    |=> resp_reg == $past(bank_w[0][W-1:0])
  ) else $error("x rate fine word wrong");

  x_rate_coarse_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_X_RATE_COARSE_ADDR
    |=> resp_reg == $past(bank_w[0][2*W-1:W])
  ) else $error("x rate coarse word wrong");

  y_rate_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Y_RATE_FINE_ADDR
    |=> resp_reg == $past(bank_w[1][W-1:0])
  ) else $error("y rate fine word wrong");

  y_rate_coarse_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Y_RATE_COARSE_ADDR
    |=> resp_reg == $past(bank_w[1][2*W-1:W])
  ) else $error("y rate coarse word wrong");

  z_rate_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Z_RATE_FINE_ADDR
    |=> resp_reg == $past(bank_w[2][W-1:0])
  ) else $error("z rate fine word wrong");

  z_rate_coarse_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Z_RATE_COARSE_ADDR
    |=> resp_reg == $past(bank_w[2][2*W-1:W])
  ) else $error("z rate coarse word wrong");

  rate_pair_a: assert property (
    rd_stb && partner_hit && rd_axis == last_axis_reg && rd_axis < `IORG_GYRO_AXES
    |=> resp_reg == $past(exp_half)
  ) else $error("rate halves not from one update");

  accel_pair_a: assert property (
    rd_stb && partner_hit && rd_axis == last_axis_reg && rd_axis >= `IORG_GYRO_AXES
    |=> resp_reg == $past(exp_half)
  ) else $error("accel halves not from one update");

  x_accel_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_X_ACCEL_FINE_ADDR
    |=> resp_reg == $past(bank_w[3][W-1:0])
  ) else $error("x accel fine word wrong");

  x_accel_coarse_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_X_ACCEL_COARSE_ADDR
    |=> resp_reg == $past(bank_w[3][2*W-1:W])
  ) else $error("x accel coarse word wrong");

  y_accel_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Y_ACCEL_FINE_ADDR
    |=> resp_reg == $past(bank_w[4][W-1:0])
  ) else $error("y accel fine word wrong");

  y_accel_coarse_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Y_ACCEL_COARSE_ADDR
    |=> resp_reg == $past(bank_w[4][2*W-1:W])
  ) else $error("y accel coarse word wrong");

  z_accel_fine_a: assert property (
    rd_stb && !partner_hit && word_addr == `IORG_Z_ACCEL_FINE_ADDR
    |=> resp_reg == $past(bank_w[5][W-1:0])
  ) else $error("z accel fine word wrong");

  write_ignored_a: assert property (
    cmd_done && cmd_wr && !sample_valid_in
    |=> bank_w == $past(bank_w) && resp_reg == `IORG_RESP_RST
  ) else $error("write frame altered the bank");

  update_between_a: assert property (
    rd_stb && partner_hit && rd_axis == last_axis_reg && upd_since_reg
    |=> resp_reg == $past(exp_half)
  ) else $error("new update tore an axis pair");

  miso_enable_a: assert property (
    !spi_cs_n_in ##1 !spi_cs_n_in |-> spi_miso_oe_out
  ) else $error("output not driven while selected");

  bank_load_a: assert property (
    sample_valid_in |=> bank_w == $past(sample_bus)
  ) else $error("update did not land whole");

  bank_hold_a: assert property (
    !sample_valid_in |=> bank_w == $past(bank_w)
  ) else $error("bank changed without an update");

  unmapped_zero_a: assert property (
    cmd_done && !cmd_wr && !mapped |=> resp_reg == `IORG_RESP_RST
  ) else $error("unmapped read gave data");

  first_bit_a: assert property (
    active && sclk_fall && bit_cnt_reg == `IORG_CNT_ZERO |=> spi_miso_out == $past(resp_reg[W-1])
  ) else $error("first answer bit wrong");

  next_bit_a: assert property (
    active && sclk_fall && bit_cnt_reg != `IORG_CNT_ZERO |=> spi_miso_out == $past(tx_reg[W-1])
  ) else $error("later answer bit wrong");

  miso_hold_a: assert property (
    !(active && sclk_fall) |=> spi_miso_out == $past(spi_miso_out)
  ) else $error("answer bit moved off a falling edge");

  oe_release_a: assert property (
    spi_cs_n_in ##1 spi_cs_n_in |-> !spi_miso_oe_out
  ) else $error("output driven while deselected");

  frame_err_set_a: assert property (
    state_reg == IORG_SHIFT && spi_cs_n_in && bit_cnt_reg != `IORG_CNT_ZERO |=> frame_err_out
  ) else $error("cut frame not flagged");

  frame_err_clear_a: assert property (
    state_reg == IORG_SHIFT && spi_cs_n_in && bit_cnt_reg == `IORG_CNT_ZERO |=> !frame_err_out
  ) else $error("clean frame left the flag set");

  cnt_clear_a: assert property (
    !active |=> bit_cnt_reg == `IORG_CNT_ZERO
  ) else $error("bit count kept outside a frame");

  resp_hold_a: assert property (
    !cmd_done |=> resp_reg == $past(resp_reg)
  ) else $error("pending answer changed mid word");
endmodule : iorg_top

// ### verification/iorg_host.sv
// Host model driving the serial port in mode 3
`timescale 1ns/100ps
module iorg_host (
  input wire logic clk_in,
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Released data line shows the inverse of its last level
  task automatic select(input logic on);
    @(posedge clk_in);
    cs_n_out <= ~on;
    if (!on) mosi_out <= ~mosi_out;
    repeat (4) @(posedge clk_in);
  endtask : select
  // Shifts n bits MSB first, data set on fall, answer taken before rise
  task automatic word(input logic [15:0] cmd, input int n, output logic [15:0] ans);
    ans = 16'h0000;
    for (int i = 15; i > 15 - n; i--) begin
      @(posedge clk_in);
      sclk_out <= 1'b0;
      mosi_out <= cmd[i];
      repeat (5) @(posedge clk_in);
      @(negedge clk_in);
      ans[i] = miso_oe_in ? miso_in : 1'bx;
      @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
  endtask : word
endmodule : iorg_host

// ### verification/test_iorg_top.sv
// Self-checking testbench for the inertial output register bank
`timescale 1ns/100ps
module test_iorg_top;
  import iorg_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sample_valid_in = 1'b0;
  logic [31:0] x_rate;
  logic [31:0] y_rate;
  logic [31:0] z_rate;
  logic [31:0] x_accel;
  logic [31:0] y_accel;
  logic [31:0] z_accel;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic frame_err;
  int fail_count = 0;
  int samples_checked = 0;
  always #2.5 clk_in = ~clk_in;
  iorg_top iorg_top_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sample_valid_in(sample_valid_in), .x_rate_in(x_rate), .y_rate_in(y_rate),
    .z_rate_in(z_rate), .x_accel_in(x_accel), .y_accel_in(y_accel), .z_accel_in(z_accel),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(miso_oe), .frame_err_out(frame_err));
  iorg_host iorg_host_i (.clk_in(clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
    .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] rd(input logic [6:0] a);
    return {1'b0, a, 8'h00};
  endfunction : rd
  function automatic logic [31:0] val(input logic [31:0] base, input int a);
    return base + 32'h0101_0101 * a;
  endfunction : val
  // Word k of the map: axis k/2, fine half on even k
  function automatic logic [15:0] half(input logic [31:0] base, input int k);
    logic [31:0] v;
    v = val(base, k / 2);
    return (k % 2) ? v[31:16] : v[15:0];
  endfunction : half
  task automatic load(input logic [31:0] base);
    @(posedge clk_in);
    x_rate <= val(base, 0);
    y_rate <= val(base, 1);
    z_rate <= val(base, 2);
    x_accel <= val(base, 3);
    y_accel <= val(base, 4);
    z_accel <= val(base, 5);
    sample_valid_in <= 1'b1;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
  endtask : load
  // One word in the open frame; its answer belongs to the previous word
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] exp);
    logic [15:0] ans;
    iorg_host_i.word(cmd, 16, ans);
    check("answer", ans, exp);
  endtask : xfer
  task automatic t_reset;
    check("idle oe", {15'h0, miso_oe}, 16'h0000);
    check("frame err", {15'h0, frame_err}, 16'h0000);
    iorg_host_i.select(1'b1);
    check("drive oe", {15'h0, miso_oe}, 16'h0001);
    xfer(rd(7'h06), 16'h0000);
    xfer(rd(7'h04), 16'h0000);
    xfer(rd(7'h00), 16'h0000);
    iorg_host_i.select(1'b0);
    check("release oe", {15'h0, miso_oe}, 16'h0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_map;
    logic [15:0] prev;
    logic [6:0] a;
    prev = 16'h0000;
    load(32'h8123_f456);
    iorg_host_i.select(1'b1);
    for (int k = 0; k < 11; k++) begin
      a = 7'h04 + 7'(2 * k) + 7'(k % 3 == 1);
      xfer(rd(a), prev);
      prev = half(32'h8123_f456, k);
    end
    xfer(rd(7'h1a), prev);
    xfer(rd(7'h00), 16'h0000);
    iorg_host_i.select(1'b0);
    $display("map test done");
  endtask : t_map
  task automatic t_pair;
    load(32'h1234_5678);
    iorg_host_i.select(1'b1);
    xfer(rd(7'h08), 16'h0000);
    load(32'hfedc_ba98);
    xfer(rd(7'h0a), half(32'h1234_5678, 2));
    xfer(rd(7'h0a), half(32'h1234_5678, 3));
    xfer(rd(7'h12), half(32'hfedc_ba98, 3));
    load(32'h0f0f_7070);
    xfer(rd(7'h10), half(32'hfedc_ba98, 7));
    xfer(rd(7'h00), half(32'hfedc_ba98, 6));
    iorg_host_i.select(1'b0);
    $display("pair test done");
  endtask : t_pair
  task automatic t_write;
    iorg_host_i.select(1'b1);
    xfer({1'b1, 7'h06, 8'hab}, 16'h0000);
    xfer({1'b1, 7'h07, 8'h55}, 16'h0000);
    xfer(rd(7'h06), 16'h0000);
    xfer(rd(7'h00), half(32'h0f0f_7070, 1));
    iorg_host_i.select(1'b0);
    $display("write test done");
  endtask : t_write
  task automatic t_frame;
    logic [15:0] ans;
    iorg_host_i.select(1'b1);
    iorg_host_i.word(rd(7'h0e), 8, ans);
    iorg_host_i.select(1'b0);
    check("frame err", {15'h0, frame_err}, 16'h0001);
    iorg_host_i.select(1'b1);
    xfer(rd(7'h00), 16'h0000);
    iorg_host_i.select(1'b0);
    check("frame err", {15'h0, frame_err}, 16'h0000);
    $display("frame test done");
  endtask : t_frame
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_reset;
    t_map;
    t_pair;
    t_write;
    t_frame;
    stop_test;
  end
endmodule : test_iorg_top
